// *** design/mvd_stream_order.sv ***
// What this block does
// - random access components must not reference any earlier access unit
// - no reference may reach before the latest random access unit
// - components inside an access unit come in ascending tag order
// - independent view: video picture before its depth map
// - dependent views accept video and depth in either order
// - same tag means same camera position; tags reveal missing views
// - signed rank: smaller rank sits left when ordering output
// - vertical disparity component is always zero
// - horizontal disparity is (scale*depth + offset) arithmetically shifted right
// - each video and depth sequence owns separate parameter set entries
// - non-base parameters carry tag, depth flag, rank, camera placement
// - in-parameter camera data holds two pairs per smaller tag
// - base view without extension infers tag, depth flag, rank zero
// - constant flag: parameter-set scale/offset, else slice header values
// - base-view packets found from parameter sets and slice set id
// - prediction from depth can be disabled so video survives depth drop
// - extraction drops depth and dependent-view packets
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mvd_stream_order #(
  parameter int NPS  = 16,
  parameter int TAGW = 4,
  parameter int DW   = 16
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   ps_valid,
  input  wire logic [$clog2(NPS)-1:0] ps_id,
  input  wire logic                   ps_has_ext,
  input  wire logic [TAGW-1:0]        ps_tag,
  input  wire logic                   ps_depth,
  input  wire logic signed [7:0]      ps_rank,
  input  wire logic                   ps_cam_const,
  input  wire logic                   comp_valid,
  input  wire logic [$clog2(NPS)-1:0] comp_ps_id,
  input  wire logic                   comp_au_first,
  input  wire logic                   comp_random,
  input  wire logic                   comp_ref_prev_au,
  input  wire logic                   comp_ref_before_ra,
  input  wire logic signed [15:0]     slice_scale,
  input  wire logic signed [15:0]     slice_offset,
  input  wire logic                   depth_valid,
  input  wire logic [DW-1:0]          depth_sample,
  output logic                        out_valid,
  output logic [TAGW-1:0]             out_tag,
  output logic                        out_depth,
  output logic signed [7:0]           out_rank,
  output logic                        out_keep_base,
  output logic                        out_depth_pred_ok,
  output logic [TAGW:0]               out_cam_pairs,
  output logic                        disp_valid,
  output logic signed [31:0]          disp_h,
  output logic signed [31:0]          disp_v,
  output logic                        irq
);
  if (NPS < 2 || TAGW < 1 || TAGW > 8 || DW < 1 || DW > 16) begin : g_bad_param
    $error("mvd_stream_order: parameter out of range");
  end
  localparam int PSW = $clog2(NPS);
  // ------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------
  logic               aw_held_r, w_held_r;
  logic [7:0]         awaddr_r;
  logic [31:0]        wdata_r;
  logic [3:0]         wstrb_r;
  logic               wr_go;
  logic [31:0]        ctrl_r, mask_r, baseps_r, rdata_nxt;
  logic [mvd_stream_pkg::NUM_EV-1:0] status_r, ev;
  logic [4:0]         shift_r;
  logic signed [15:0] scale_r, offset_r;
  logic [31:0]        info_r;
  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= mvd_stream_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r[7:5] == 3'h0 && awaddr_r[1:0] == 2'h0 &&
                         awaddr_r != mvd_stream_pkg::ADDR_INFO) ?
                        mvd_stream_pkg::RESP_OKAY : mvd_stream_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // register writes; byte lane 0 covers shift, lanes 0 and 1 cover scale and offset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r   <= mvd_stream_pkg::CTRL_RST;
      mask_r   <= 32'h0000_0000;
      shift_r  <= mvd_stream_pkg::SHIFT_RST;
      baseps_r <= 32'h0000_0000;
      scale_r  <= 16'sh0001;
      offset_r <= 16'sh0000;
    end else if (wr_go) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_r[b]) begin
          if (awaddr_r == mvd_stream_pkg::ADDR_CTRL)   ctrl_r[b*8 +: 8]   <= wdata_r[b*8 +: 8];
          if (awaddr_r == mvd_stream_pkg::ADDR_MASK)   mask_r[b*8 +: 8]   <= wdata_r[b*8 +: 8];
          if (awaddr_r == mvd_stream_pkg::ADDR_BASEPS) baseps_r[b*8 +: 8] <= wdata_r[b*8 +: 8];
        end
      end
      if (awaddr_r == mvd_stream_pkg::ADDR_SHIFT && wstrb_r[0]) shift_r <= wdata_r[4:0];
      if (awaddr_r == mvd_stream_pkg::ADDR_SCALE) begin
        if (wstrb_r[0]) scale_r[7:0]  <= wdata_r[7:0];
        if (wstrb_r[1]) scale_r[15:8] <= wdata_r[15:8];
      end
      if (awaddr_r == mvd_stream_pkg::ADDR_OFFSET) begin
        if (wstrb_r[0]) offset_r[7:0]  <= wdata_r[7:0];
        if (wstrb_r[1]) offset_r[15:8] <= wdata_r[15:8];
      end
    end
  end
  // status: write one to clear, a new event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= '0;
      irq      <= 1'b0;
    end else begin
      if (wr_go && awaddr_r == mvd_stream_pkg::ADDR_STATUS && wstrb_r[0]) begin
        status_r <= (status_r & ~wdata_r[mvd_stream_pkg::NUM_EV-1:0]) | ev;
      end else begin
        status_r <= status_r | ev;
      end
      irq <= |(status_r & mask_r[mvd_stream_pkg::NUM_EV-1:0]);
    end
  end
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (s_axi_araddr == mvd_stream_pkg::ADDR_CTRL) begin
      rdata_nxt = ctrl_r;
    end else if (s_axi_araddr == mvd_stream_pkg::ADDR_STATUS) begin
      rdata_nxt[mvd_stream_pkg::NUM_EV-1:0] = status_r;
    end else if (s_axi_araddr == mvd_stream_pkg::ADDR_MASK) begin
      rdata_nxt = mask_r;
    end else if (s_axi_araddr == mvd_stream_pkg::ADDR_SHIFT) begin
      rdata_nxt[4:0] = shift_r;
    end else if (s_axi_araddr == mvd_stream_pkg::ADDR_BASEPS) begin
      rdata_nxt = baseps_r;
    end else if (s_axi_araddr == mvd_stream_pkg::ADDR_INFO) begin
      rdata_nxt = info_r;
    end else if (s_axi_araddr == mvd_stream_pkg::ADDR_SCALE) begin
      rdata_nxt[15:0] = scale_r;
    end else if (s_axi_araddr == mvd_stream_pkg::ADDR_OFFSET) begin
      rdata_nxt[15:0] = offset_r;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= mvd_stream_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdata_nxt;
        s_axi_rresp  <= (s_axi_araddr[7:5] == 3'h0 && s_axi_araddr[1:0] == 2'h0) ?
                        mvd_stream_pkg::RESP_OKAY : mvd_stream_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ------------------------------------------------------------
  // parameter-set table, one entry per set id
  // ------------------------------------------------------------
  logic [TAGW-1:0]    tab_tag_r   [NPS];
  logic               tab_depth_r [NPS];
  logic signed [7:0]  tab_rank_r  [NPS];
  logic               tab_const_r [NPS];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NPS; i++) begin
        tab_tag_r[i]   <= '0;
        tab_depth_r[i] <= 1'b0;
        tab_rank_r[i]  <= 8'sh00;
        tab_const_r[i] <= 1'b1;
      end
    end else if (ps_valid) begin
      tab_tag_r[ps_id]   <= ps_has_ext ? ps_tag : '0;
      tab_depth_r[ps_id] <= ps_has_ext && ps_depth;
      tab_rank_r[ps_id]  <= ps_has_ext ? ps_rank : 8'sh00;
      tab_const_r[ps_id] <= !ps_has_ext || ps_cam_const;
    end
  end
  // ------------------------------------------------------------
  // coding order check per access unit
  // ------------------------------------------------------------
  logic [TAGW-1:0] c_tag, last_tag_r, max_tag_r;
  logic            c_depth, seen_vid_r, seen_dep_r, au_open_r;
  logic [7:0]      nviews;
  assign c_tag   = tab_tag_r[comp_ps_id];
  assign c_depth = tab_depth_r[comp_ps_id];
  assign nviews  = ctrl_r[mvd_stream_pkg::CTRL_NVIEWS_LSB +: 8];
  always_comb begin
    ev = '0;
    if (comp_valid) begin
      if (comp_au_first) begin
        ev[mvd_stream_pkg::EV_ORDER]   = (c_tag != '0);
        ev[mvd_stream_pkg::EV_MISSING] = (c_tag != '0) ||
          (au_open_r && ({4'h0, max_tag_r} + 9'h001 < {1'b0, nviews}));
      end else begin
        ev[mvd_stream_pkg::EV_ORDER]   = (c_tag < last_tag_r);
        ev[mvd_stream_pkg::EV_MISSING] = (c_tag < last_tag_r) ||
          ({1'b0, c_tag} > {1'b0, last_tag_r} + 1'b1);
      end
      // base view: depth must follow video of tag zero
      ev[mvd_stream_pkg::EV_BASEORD] = (c_tag == '0) && c_depth &&
        (comp_au_first || !seen_vid_r || last_tag_r != '0);
      ev[mvd_stream_pkg::EV_RANDOM]  = (comp_random && comp_ref_prev_au) ||
                                       comp_ref_before_ra;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_tag_r <= '0;
      max_tag_r  <= '0;
      seen_vid_r <= 1'b0;
      seen_dep_r <= 1'b0;
      au_open_r  <= 1'b0;
    end else if (comp_valid) begin
      au_open_r  <= 1'b1;
      last_tag_r <= c_tag;
      // same tag, any video/depth order for dependent views
      if (comp_au_first || c_tag != last_tag_r) begin
        seen_vid_r <= !c_depth;
        seen_dep_r <= c_depth;
      end else begin
        seen_vid_r <= seen_vid_r | !c_depth;
        seen_dep_r <= seen_dep_r | c_depth;
      end
      if (comp_au_first || c_tag > max_tag_r) max_tag_r <= c_tag;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid         <= 1'b0;
      out_tag           <= '0;
      out_depth         <= 1'b0;
      out_rank          <= 8'sh00;
      out_keep_base     <= 1'b0;
      out_depth_pred_ok <= 1'b1;
      out_cam_pairs     <= '0;
      info_r            <= 32'h0000_0000;
    end else begin
      out_valid     <= comp_valid;
      out_tag       <= c_tag;
      out_depth     <= c_depth;
      out_rank      <= tab_rank_r[comp_ps_id];
      out_keep_base <= comp_valid && !c_depth && c_tag == '0 &&
                       comp_ps_id == baseps_r[PSW-1:0];
      out_depth_pred_ok <= !ctrl_r[mvd_stream_pkg::CTRL_DEPTH_INDEP];
      out_cam_pairs <= tab_const_r[comp_ps_id] ? {c_tag, 1'b0} : '0;
      info_r        <= {16'h0000, 7'h00, seen_dep_r, seen_vid_r, au_open_r,
                        6'h00} | {24'h000000, 8'(last_tag_r)};
    end
  end
  // ------------------------------------------------------------
  // depth to disparity
  // ------------------------------------------------------------
  logic signed [15:0] use_scale, use_offset;
  logic signed [33:0] prod;
  logic               cam_const_r;
  // camera placement of the latest component
  always_ff @(posedge aclk) begin
    if (!aresetn) cam_const_r <= 1'b1;
    else if (comp_valid) cam_const_r <= tab_const_r[comp_ps_id];
  end
  assign use_scale  = cam_const_r ? scale_r : slice_scale;
  assign use_offset = cam_const_r ? offset_r : slice_offset;
  assign prod = 34'(use_scale * $signed({1'b0, depth_sample})) + 34'(use_offset);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disp_valid <= 1'b0;
      disp_h     <= 32'sh0;
      disp_v     <= 32'sh0;
    end else begin
      disp_valid <= depth_valid;
      if (depth_valid) disp_h <= 32'(prod >>> shift_r);
      disp_v <= 32'sh0;
    end
  end
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_BACKWARD_TAG: assert property (@(posedge aclk) disable iff (!aresetn)
    comp_valid && !comp_au_first && c_tag < last_tag_r |=> status_r[mvd_stream_pkg::EV_ORDER])
    else $error("backward tag not flagged");
  AST_SKIP_TAG: assert property (@(posedge aclk) disable iff (!aresetn)
    comp_valid && !comp_au_first && {1'b0, c_tag} > {1'b0, last_tag_r} + 1'b1
    |=> status_r[mvd_stream_pkg::EV_MISSING])
    else $error("skipped tag not flagged");
  AST_BASE_ORDER: assert property (@(posedge aclk) disable iff (!aresetn)
    comp_valid && comp_au_first && c_depth && c_tag == '0
    |=> status_r[mvd_stream_pkg::EV_BASEORD])
    else $error("base depth first not flagged");
  AST_DEP_ANY_ORDER: assert property (@(posedge aclk) disable iff (!aresetn)
    comp_valid && !comp_au_first && c_tag == last_tag_r && c_tag != '0
    |-> !ev[mvd_stream_pkg::EV_BASEORD] && !ev[mvd_stream_pkg::EV_ORDER])
    else $error("dependent view order wrongly flagged");
  AST_RANDOM_REF: assert property (@(posedge aclk) disable iff (!aresetn)
    comp_valid && comp_ref_before_ra |=> status_r[mvd_stream_pkg::EV_RANDOM])
    else $error("stale reference not flagged");
  AST_VERT_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    disp_valid |-> disp_v == 32'sh0)
    else $error("vertical disparity not zero");
  AST_DISP_CALC: assert property (@(posedge aclk) disable iff (!aresetn)
    depth_valid |=> disp_h == 32'($past(prod) >>> $past(shift_r)))
    else $error("horizontal disparity wrong");
  AST_KEEP_BASE: assert property (@(posedge aclk) disable iff (!aresetn)
    out_keep_base |-> !out_depth && out_tag == '0 && out_valid)
    else $error("non-base packet kept");
  AST_BASE_INFER: assert property (@(posedge aclk) disable iff (!aresetn)
    ps_valid && !ps_has_ext |=> tab_tag_r[$past(ps_id)] == '0 &&
    !tab_depth_r[$past(ps_id)] && tab_rank_r[$past(ps_id)] == 8'sh00)
    else $error("base view inference wrong");
  AST_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
    |(status_r & mask_r[mvd_stream_pkg::NUM_EV-1:0]) |=> irq)
    else $error("interrupt not raised");
endmodule // mvd_stream_order
`default_nettype wire

// *** design/mvd_stream_pkg.sv ***
package mvd_stream_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK   = 8'h08;
  localparam logic [7:0] ADDR_SHIFT  = 8'h0c;
  localparam logic [7:0] ADDR_BASEPS = 8'h10;
  localparam logic [7:0] ADDR_INFO   = 8'h14;
  localparam logic [7:0] ADDR_SCALE  = 8'h18;
  localparam logic [7:0] ADDR_OFFSET = 8'h1c;
  // ------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------
  localparam int CTRL_DEPTH_INDEP = 0;
  localparam int CTRL_NVIEWS_LSB  = 8;
  localparam int EV_ORDER   = 0;
  localparam int EV_BASEORD = 1;
  localparam int EV_MISSING = 2;
  localparam int EV_RANDOM  = 3;
  localparam int NUM_EV     = 4;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0200;
  localparam logic [4:0]  SHIFT_RST = 5'h00;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// *** tb/nal_source.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// nal stream source model
// ----------------------------------------
module nal_source (
  input  wire logic         aclk,
  output logic              ps_valid,
  output logic [3:0]        ps_id,
  output logic              ps_has_ext,
  output logic [3:0]        ps_tag,
  output logic              ps_depth,
  output logic signed [7:0] ps_rank,
  output logic              ps_cam_const,
  output logic              comp_valid,
  output logic [3:0]        comp_ps_id,
  output logic              comp_au_first,
  output logic              comp_random,
  output logic              comp_ref_prev_au,
  output logic              comp_ref_before_ra,
  output logic signed [15:0] slice_scale,
  output logic signed [15:0] slice_offset,
  output logic              depth_valid,
  output logic [15:0]       depth_sample
);
  initial begin
    {ps_valid, ps_id, ps_has_ext, ps_tag, ps_depth, ps_rank, ps_cam_const} = 20'h0;
    {comp_valid, comp_ps_id, comp_au_first, comp_random, comp_ref_prev_au} = 8'h0;
    {comp_ref_before_ra, slice_scale, slice_offset, depth_valid, depth_sample} = 50'h0;
  end
  // separate entry per video and depth sequence
  // extension holds tag, depth flag, rank, camera placement
  task automatic put_ps(input logic [3:0] i, input logic e, input logic [3:0] t,
                        input logic d, input logic [7:0] r, input logic c);
    @(posedge aclk);
    {ps_valid, ps_id, ps_has_ext, ps_tag, ps_depth, ps_rank, ps_cam_const} <=
      {1'b1, i, e, t, d, r, c};
    @(posedge aclk);
    {ps_valid, ps_id, ps_tag, ps_rank} <= {1'b0, ~i, ~t, ~r};
  endtask
  // order and references exactly as commanded
  task automatic put_comp(input logic [3:0] i, input logic f, input logic ra,
                          input logic p, input logic b);
    @(posedge aclk);
    {comp_valid, comp_ps_id, comp_au_first, comp_random, comp_ref_prev_au,
     comp_ref_before_ra} <= {1'b1, i, f, ra, p, b};
    @(posedge aclk);
    {comp_valid, comp_ps_id} <= {1'b0, ~i};
  endtask
  // slice header camera values for non-constant entries
  task automatic put_slice(input logic [15:0] s, input logic [15:0] o);
    @(posedge aclk);
    {slice_scale, slice_offset} <= {s, o};
  endtask
  task automatic put_depth(input logic [15:0] v);
    @(posedge aclk);
    {depth_valid, depth_sample} <= {1'b1, v};
    @(posedge aclk);
    {depth_valid, depth_sample} <= {1'b0, ~v};
  endtask
endmodule // nal_source
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic ps_valid, ps_has_ext, ps_depth, ps_cam_const, comp_valid, comp_au_first;
  wire logic comp_random, comp_ref_prev_au, comp_ref_before_ra, depth_valid;
  wire logic [3:0] ps_id, ps_tag, comp_ps_id, out_tag;
  wire logic signed [7:0] ps_rank, out_rank;
  wire logic signed [15:0] slice_scale, slice_offset;
  wire logic [15:0] depth_sample;
  wire logic out_valid, out_depth, out_keep_base, out_depth_pred_ok, disp_valid, irq;
  wire logic [4:0] out_cam_pairs;
  wire logic signed [31:0] disp_h, disp_v;
  wire logic [18:0] out_pack = {out_tag, out_depth, out_rank, out_keep_base, out_cam_pairs};
  int fails = 0;
  int cmp_count = 0;
  logic [18:0] oq[$];
  logic [63:0] dq[$];
  logic [33:0] aq[$];
  logic [3:0] mt[16];
  logic md[16], mc[16], lc;
  logic [7:0] mr[16];
  logic signed [15:0] rs, ro, ss, so;
  logic [4:0] sh;
  nal_source src (.aclk, .ps_valid, .ps_id, .ps_has_ext, .ps_tag, .ps_depth, .ps_rank,
    .ps_cam_const, .comp_valid, .comp_ps_id, .comp_au_first, .comp_random, .comp_ref_prev_au,
    .comp_ref_before_ra, .slice_scale, .slice_offset, .depth_valid, .depth_sample);
  mvd_stream_order DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ps_valid, .ps_id, .ps_has_ext, .ps_tag, .ps_depth,
    .ps_rank, .ps_cam_const, .comp_valid, .comp_ps_id, .comp_au_first, .comp_random,
    .comp_ref_prev_au, .comp_ref_before_ra, .slice_scale, .slice_offset, .depth_valid,
    .depth_sample, .out_valid, .out_tag, .out_depth, .out_rank, .out_keep_base,
    .out_depth_pred_ok, .out_cam_pairs, .disp_valid, .disp_h, .disp_v, .irq);
  initial forever #4 aclk = ~aclk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    aq.push_back({r, 32'h0});
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <=
      {a, d, 4'hf, 3'b111};
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    aq.push_back({r, d});
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  task automatic ps(input int i, input logic e, input logic [3:0] t, input logic d,
                    input logic [7:0] r, input logic c);
    src.put_ps(4'(i), e, t, d, r, c);
    {mt[i], md[i], mr[i], mc[i]} = e ? {t, d, r, c} : {4'h0, 1'b0, 8'h0, 1'b1};
  endtask
  task automatic cp(input int i, input int f, input int ra, input int p, input int b);
    oq.push_back({mt[i], md[i], mr[i], mt[i] == 4'h0 && !md[i] && i == 0,
                  mc[i] ? {mt[i], 1'b0} : 5'h0});
    lc = mc[i];
    src.put_comp(4'(i), 1'(f), 1'(ra), 1'(p), 1'(b));
  endtask
  task automatic dp(input logic [15:0] v);
    longint x;
    x = (lc ? longint'(rs) : longint'(ss)) * longint'(v) + (lc ? longint'(ro) : longint'(so));
    x = x >>> sh;
    dq.push_back({x[31:0], 32'h0});
    src.put_depth(v);
  endtask
  // ----------------------------------------
  // monitor and sequence
  // ----------------------------------------
  always @(posedge aclk) begin
    if (out_valid === 1'b1) chk(64'(out_pack), 64'(oq.pop_front()));
    if (disp_valid === 1'b1) chk({disp_h, disp_v}, dq.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk({30'h0, s_axi_rresp, s_axi_rdata}, 64'(aq.pop_front()));
    if (s_axi_bvalid && s_axi_bready) chk({30'h0, s_axi_bresp, 32'h0}, 64'(aq.pop_front()));
  end
  initial begin
    #400000;
    fails++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h457bdb08));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(mvd_stream_pkg::ADDR_CTRL, mvd_stream_pkg::CTRL_RST, mvd_stream_pkg::RESP_OKAY);
    rd(8'h18, 32'h1, 2'h0);
    for (int i = 0; i < 3; i++) rd(8'h04 + 8'(4 * i), 32'h0, 2'h0);
    rd(8'h1c, 32'h0, 2'h0);
    rd(8'h20, 32'h0, 2'h2);
    rd(8'h06, 32'h0, 2'h2);
    wr(8'h14, 32'h1, 2'h2);
    wr(8'h10, 32'h0, 2'h0);
    wr(8'h08, 32'hf, 2'h0);
    rd(8'h08, 32'hf, 2'h0);
    wr(8'h08, 32'h0, 2'h0);
    $display("test registers done");
    ps(0, 1'b0, 4'($urandom), 1'b1, 8'($urandom), 1'b0);
    ps(1, 1'b1, 4'h0, 1'b1, 8'($urandom), 1'b1);
    ps(2, 1'b1, 4'h1, 1'b0, 8'hfd, 1'b1);
    ps(3, 1'b1, 4'h1, 1'b1, 8'($urandom), 1'b0);
    ps(4, 1'b1, 4'h3, 1'b0, 8'h05, 1'b1);
    cp(0, 1, 1, 0, 0);
    cp(1, 0, 0, 0, 0);
    cp(3, 0, 0, 0, 0);
    cp(2, 0, 0, 0, 0);
    rd(8'h04, 32'h0, 2'h0);
    $display("test order and lookup done");
    cp(0, 1, 0, 0, 0);
    cp(4, 0, 0, 0, 0);
    rd(8'h04, 32'h4, 2'h0);
    repeat (3) @(posedge aclk);
    chk(64'(irq), 64'h0);
    wr(8'h08, 32'h4, 2'h0);
    repeat (3) @(posedge aclk);
    chk(64'(irq), 64'h1);
    wr(8'h04, 32'h4, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    chk(64'(irq), 64'h0);
    $display("test missing view done");
    cp(1, 1, 0, 0, 0);
    cp(0, 0, 0, 0, 0);
    cp(2, 0, 0, 0, 0);
    rd(8'h04, 32'h2, 2'h0);
    wr(8'h04, 32'h2, 2'h0);
    cp(0, 1, 0, 0, 0);
    cp(2, 0, 0, 0, 0);
    cp(1, 0, 0, 0, 0);
    rd(8'h04, 32'h7, 2'h0);
    wr(8'h04, 32'h7, 2'h0);
    for (int k = 0; k < 2; k++) begin
      cp(0, 1, int'(k == 0), int'(k == 0), int'(k == 1));
      cp(2, 0, 0, 0, 0);
      rd(8'h04, 32'h8, 2'h0);
      wr(8'h04, 32'h8, 2'h0);
    end
    $display("test errors done");
    wr(8'h00, 32'h201, 2'h0);
    repeat (2) @(posedge aclk);
    chk(64'(out_depth_pred_ok), 64'h0);
    wr(8'h00, 32'h200, 2'h0);
    repeat (2) @(posedge aclk);
    chk(64'(out_depth_pred_ok), 64'h1);
    sh = 5'($urandom_range(0, 7));
    rs = 16'($urandom_range(0, 2000) - 1000);
    ro = 16'($urandom);
    ss = 16'($urandom_range(0, 2000) - 1000);
    so = 16'($urandom);
    wr(8'h0c, 32'(sh), 2'h0);
    wr(8'h18, 32'(rs), 2'h0);
    wr(8'h1c, 32'(ro), 2'h0);
    src.put_slice(ss, so);
    cp(0, 1, 0, 0, 0);
    cp(2, 0, 0, 0, 0);
    for (int j = 0; j < 4; j++) dp(16'($urandom));
    cp(3, 0, 0, 0, 0);
    for (int j = 0; j < 4; j++) dp(16'($urandom));
    repeat (5) @(posedge aclk);
    chk(64'(oq.size() + dq.size() + aq.size()), 64'h0);
    $display("test disparity done");
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
